/* inc/ramon_pkg.sv */
// package: shared constants and carrier types of the rail alert monitor
package ramon_pkg;
  // ==========================================
  // widths and counts
  localparam int NCH = 3;
  localparam int DW  = 13;
  localparam int AW  = 3;
  localparam int TCW = 3;
  // ==========================================
  // reset values of limits, bus LSB is 8 mV
  localparam logic signed [12:0] WARN_LIMIT_RST = 13'sh0fff;
  localparam logic [12:0] PV_UPPER_RST = 13'h04e2;
  localparam logic [12:0] PV_LOWER_RST = 13'h0465;
  localparam logic [12:0] SEQ_THRESH   = 13'h0096;
  localparam logic [2:0]  SEQ_CYCLES   = 3'h4;
  // ==========================================
  // timing figure of the sequence check window
  localparam real SEQ_WINDOW_MS = 28.6;
  // ==========================================
  // conversion result strobe from the sequencer
  typedef struct packed {
    logic              valid;
    logic              is_bus;
    logic [1:0]        chan;
    logic signed [12:0] value;
  } ramon_conv_t;
  // per-channel warning limits
  typedef struct packed {
    logic signed [12:0] lim2;
    logic signed [12:0] lim1;
    logic signed [12:0] lim0;
  } ramon_wlim_t;
endpackage : ramon_pkg

/* design/ramon_avg.sv */
// module: running average of one shunt channel
`timescale 1ns/1ps
module ramon_avg (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  input  wire logic               soft_rst,
  // new sample
  input  wire logic               sample_valid,
  input  wire logic signed [12:0] sample,
  input  wire logic [2:0]         averaging_select,
  // averaged result
  output logic signed [12:0]      avg_r,
  output logic                    upd_r
);
  logic signed [13:0] diff;
  logic signed [13:0] step;
  // divide the difference by a power of two set by the select
  always_comb begin
    diff = 14'(sample) - 14'(avg_r);
    step = diff >>> averaging_select;
  end
  // output register refreshed on every conversion of the channel
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      avg_r <= 13'sh0000;
      upd_r <= 1'b0;
    end else if (soft_rst) begin
      avg_r <= 13'sh0000;
      upd_r <= 1'b0;
    end else begin
      upd_r <= sample_valid;
      if (sample_valid) begin
        avg_r <= 13'(14'(avg_r) + step);
      end
    end
  end
endmodule : ramon_avg

/* design/ramon_pvfsm.sv */
// module: power-valid hysteresis state machine
`timescale 1ns/1ps
module ramon_pvfsm (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        soft_rst,
  // evaluation strobe and comparisons
  input  wire logic        eval,
  input  wire logic        all_above_upper,
  input  wire logic        any_below_lower,
  // state
  output logic             pv_r
);
  typedef enum logic [1:0] {PV_WAIT, PV_GOOD, PV_HOLD} ramon_pv_t;
  ramon_pv_t st_r;
  // hold the level across a soft reset until the next evaluation
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= PV_WAIT;
      pv_r <= 1'b0;
    end else if (soft_rst) begin
      st_r <= PV_HOLD;
    end else if (eval) begin
      case (st_r)
        PV_WAIT, PV_HOLD: begin
          if (all_above_upper) begin
            st_r <= PV_GOOD;
            pv_r <= 1'b1;
          end else if (st_r == PV_HOLD) begin
            st_r <= PV_WAIT;
            pv_r <= 1'b0;
          end
        end
        PV_GOOD: begin
          if (any_below_lower) begin
            st_r <= PV_WAIT;
            pv_r <= 1'b0;
          end
        end
        default: begin
          st_r <= PV_WAIT;
          pv_r <= 1'b0;
        end
      endcase
    end
  end
endmodule : ramon_pvfsm

/* design/ramon_top.sv */
// module: warning, power-valid and sequence-check alert logic
// Contract
// - averaged shunt above limit means warning
// - average refreshed per conversion, depth selectable
// - limits reset to full scale, writable anytime
// - warning pin low, channel flag set
// - power-valid watch starts at reset, upper 10V
// - power-valid low at reset, high all above
// - while valid, any below lower drops it
// - evaluate only after all three bus results
// - bus result held until reconverted
// - channel one bus compared to 1.2V
// - channel two late by four cycles fails
// - window about 28.6 ms at defaults
// - check runs only after reset events
// - config write before done disables check
// - outputs open drain, pull low only
// - soft reset restores limits, holds pv level
`timescale 1ns/1ps
module ramon_top (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  // configuration
  input  wire logic                 soft_rst,
  input  wire logic                 cfg_write,
  input  wire logic [2:0]           averaging_select,
  // warning limit write
  input  wire logic                 wlim_we,
  input  wire logic [1:0]           wlim_chan,
  input  wire logic signed [12:0]   wlim_data,
  // power-valid limit writes
  input  wire logic                 pvu_we,
  input  wire logic                 pvl_we,
  input  wire logic [12:0]          pv_lim_data,
  // conversion results
  input  ramon_pkg::ramon_conv_t    conv,
  // status readback
  output logic [2:0]                warning_flags,
  output logic signed [12:0]        shunt_avg [3],
  output logic [12:0]               bus_val [3],
  output logic [12:0]               pv_upper_r,
  output logic [12:0]               pv_lower_r,
  output logic                      seq_done_r,
  // open drain pins, oe low means driving low
  output logic                      warn_o,
  output logic                      warn_oe_b,
  output logic                      power_valid_output_o,
  output logic                      power_valid_output_oe_b,
  output logic                      sequence_check_output_o,
  output logic                      sequence_check_output_oe_b
);
  // ==========================================
  // shunt averaging and warning compare
  ramon_pkg::ramon_wlim_t wlim_r;
  logic signed [12:0] lim [3];
  logic [2:0] upd;
  logic [2:0] warn_r;
  assign lim[0] = wlim_r.lim0;
  assign lim[1] = wlim_r.lim1;
  assign lim[2] = wlim_r.lim2;

  genvar g;
  generate
    for (g = 0; g < ramon_pkg::NCH; g++) begin : g_ch
      logic avalid;
      assign avalid = conv.valid && !conv.is_bus && (conv.chan == 2'(g));
      ramon_avg u_avg (
        .clk_sys          (clk_sys),
        .rst_b            (rst_b),
        .soft_rst         (soft_rst),
        .sample_valid     (avalid),
        .sample           (conv.value),
        .averaging_select (averaging_select),
        .avg_r            (shunt_avg[g]),
        .upd_r            (upd[g])
      );
      // compare on each average refresh
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          warn_r[g] <= 1'b0;
        end else if (soft_rst) begin
          warn_r[g] <= 1'b0;
        end else if (upd[g]) begin
          warn_r[g] <= shunt_avg[g] > lim[g];
        end
      end
    end
  endgenerate

  // warning limit registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wlim_r <= {3{ramon_pkg::WARN_LIMIT_RST}};
    end else if (soft_rst) begin
      wlim_r <= {3{ramon_pkg::WARN_LIMIT_RST}};
    end else if (wlim_we) begin
      case (wlim_chan)
        2'h0:    wlim_r.lim0 <= wlim_data;
        2'h1:    wlim_r.lim1 <= wlim_data;
        2'h2:    wlim_r.lim2 <= wlim_data;
        default: wlim_r <= wlim_r;
      endcase
    end
  end
  assign warning_flags = warn_r;

  // ==========================================
  // bus result capture and power-valid limits
  logic [2:0] bus_seen_r;
  logic       pv_eval_r;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bus_val[0] <= 13'h0000;
      bus_val[1] <= 13'h0000;
      bus_val[2] <= 13'h0000;
    end else if (conv.valid && conv.is_bus && conv.chan < 2'h3) begin
      bus_val[conv.chan] <= conv.value;
    end
  end

  // all three bus results needed before an evaluation
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bus_seen_r <= 3'h0;
      pv_eval_r  <= 1'b0;
    end else if (soft_rst) begin
      bus_seen_r <= 3'h0;
      pv_eval_r  <= 1'b0;
    end else begin
      pv_eval_r <= 1'b0;
      if (conv.valid && conv.is_bus && conv.chan == 2'h2 && (&bus_seen_r[1:0])) begin
        pv_eval_r  <= 1'b1;
        bus_seen_r <= 3'h0;
      end else if (conv.valid && conv.is_bus && conv.chan < 2'h3) begin
        bus_seen_r[conv.chan] <= 1'b1;
      end
    end
  end

  // limit registers reset also by soft reset
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pv_upper_r <= ramon_pkg::PV_UPPER_RST;
      pv_lower_r <= ramon_pkg::PV_LOWER_RST;
    end else if (soft_rst) begin
      pv_upper_r <= ramon_pkg::PV_UPPER_RST;
      pv_lower_r <= ramon_pkg::PV_LOWER_RST;
    end else begin
      if (pvu_we) begin
        pv_upper_r <= pv_lim_data;
      end
      if (pvl_we) begin
        pv_lower_r <= pv_lim_data;
      end
    end
  end

  logic all_up;
  logic any_low;
  logic pv_r;
  assign all_up  = (bus_val[0] >= pv_upper_r) && (bus_val[1] >= pv_upper_r)
                   && (bus_val[2] >= pv_upper_r);
  assign any_low = (bus_val[0] < pv_lower_r) || (bus_val[1] < pv_lower_r)
                   || (bus_val[2] < pv_lower_r);

  ramon_pvfsm u_pv (
    .clk_sys         (clk_sys),
    .rst_b           (rst_b),
    .soft_rst        (soft_rst),
    .eval            (pv_eval_r),
    .all_above_upper (all_up),
    .any_below_lower (any_low),
    .pv_r            (pv_r)
  );

  // ==========================================
  // sequence check of rail two after rail one
  typedef enum logic [1:0] {SQ_CH1, SQ_CH2, SQ_PASS, SQ_FAIL} ramon_sq_t;
  ramon_sq_t sq_r;
  logic [2:0] cyc_r;
  logic       sq_off_r;
  logic       b1, b2;
  assign b1 = conv.valid && conv.is_bus && conv.chan == 2'h0;
  assign b2 = conv.valid && conv.is_bus && conv.chan == 2'h1;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sq_r     <= SQ_CH1;
      cyc_r    <= 3'h0;
      sq_off_r <= 1'b0;
    end else if (soft_rst) begin
      sq_r     <= SQ_CH1;
      cyc_r    <= 3'h0;
      sq_off_r <= 1'b0;
    end else if (cfg_write && (sq_r == SQ_CH1 || sq_r == SQ_CH2)) begin
      sq_off_r <= 1'b1;
      sq_r     <= SQ_PASS;
    end else begin
      case (sq_r)
        SQ_CH1: begin
          if (b1 && conv.value >= ramon_pkg::SEQ_THRESH) begin
            sq_r <= SQ_CH2;
          end
        end
        SQ_CH2: begin
          if (b2 && conv.value >= ramon_pkg::SEQ_THRESH) begin
            sq_r <= SQ_PASS;
          end else if (b2) begin
            // cycles counted on each rail two conversion, about 28.6 ms
            if (cyc_r == ramon_pkg::SEQ_CYCLES - 3'h1) begin
              sq_r <= SQ_FAIL;
            end
            cyc_r <= cyc_r + 3'h1;
          end
        end
        SQ_PASS: sq_r <= SQ_PASS;
        SQ_FAIL: sq_r <= SQ_FAIL;
        default: sq_r <= SQ_CH1;
      endcase
    end
  end
  assign seq_done_r = (sq_r == SQ_PASS) || (sq_r == SQ_FAIL) || sq_off_r;

  // ==========================================
  // open drain drive, output value always low
  always_comb begin
    warn_o                     = 1'b0;
    power_valid_output_o       = 1'b0;
    sequence_check_output_o    = 1'b0;
    warn_oe_b                  = !(|warn_r);
    power_valid_output_oe_b    = pv_r;
    sequence_check_output_oe_b = !(sq_r == SQ_FAIL);
  end

  // ==========================================
  // checks
  sequence s_late;
    (sq_r == SQ_CH2) && b2 && conv.value < ramon_pkg::SEQ_THRESH
      && cyc_r == 3'h3 && !cfg_write && !soft_rst;
  endsequence
  chk_warn_pin_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
    warn_oe_b == (warning_flags == 3'h0)) else $error("warn pin mismatch");
  chk_warn_cmp: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (upd[0] && !soft_rst) |=> warn_r[0] == ($past(shunt_avg[0]) > $past(lim[0])))
    else $error("warn compare wrong");
  chk_lim_reset: assert property (@(posedge clk_sys) disable iff (!rst_b)
    soft_rst |=> wlim_r.lim1 == ramon_pkg::WARN_LIMIT_RST) else $error("limit reset");
  chk_pv_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !$past(pv_eval_r) |-> $stable(pv_r)) else $error("pv changed without eval");
  chk_pv_rise: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(pv_r) |-> $past(all_up)) else $error("pv rose wrongly");
  chk_pv_fall: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (pv_r && pv_eval_r && any_low && !soft_rst) |=> !pv_r) else $error("pv not dropped");
  chk_pvlim_def: assert property (@(posedge clk_sys) disable iff (!rst_b)
    soft_rst |=> pv_upper_r == ramon_pkg::PV_UPPER_RST) else $error("pv limit reset");
  chk_seq_fail: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_late |=> !sequence_check_output_oe_b [*2]) else $error("seq fail missing");
  chk_seq_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (cfg_write && sq_r == SQ_CH1 && !soft_rst) |=> seq_done_r && sequence_check_output_oe_b)
    else $error("cfg write not disabling");
endmodule : ramon_top

/* sim/ramon_host.sv */
// host side model: resolves the open drain alert lines
`timescale 1ns/1ps
module ramon_host (
  // pin drive from the device
  input  wire logic warn_o,
  input  wire logic warn_oe_b,
  input  wire logic pv_o,
  input  wire logic pv_oe_b,
  input  wire logic seq_o,
  input  wire logic seq_oe_b,
  // levels seen by the host
  output logic      warn_line,
  output logic      pv_line,
  output logic      seq_line
);
  // =========================================
  // line levels
  // external pull-up wins while released
  assign warn_line = warn_oe_b ? 1'b1 : warn_o;
  assign pv_line   = pv_oe_b ? 1'b1 : pv_o;
  assign seq_line  = seq_oe_b ? 1'b1 : seq_o;
endmodule : ramon_host

/* sim/ramon_top_test.sv */
// testbench of the rail alert monitor
`timescale 1ns/1ps
module ramon_top_test;
  logic clk_sys = 0;
  logic rst_b = 0;
  logic soft_rst = 0, cfg_write = 0, wlim_we = 0, pvu_we = 0, pvl_we = 0;
  logic [2:0] averaging_select = 3'h0;
  logic [1:0] wlim_chan = 2'h0;
  logic signed [12:0] wlim_data = 13'h0000;
  logic [12:0] pv_lim_data = 13'h0000;
  ramon_pkg::ramon_conv_t conv = '0;
  logic [2:0] warning_flags;
  logic signed [12:0] shunt_avg [3];
  logic [12:0] bus_val [3];
  logic [12:0] pv_upper_r, pv_lower_r;
  logic seq_done_r, w_o, w_oe, p_o, p_oe, s_o, s_oe, wl, pl, sl;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  // =========================================
  // clock and timeout
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      results();
    end
  end
  ramon_top ramon_top_i (.clk_sys(clk_sys), .rst_b(rst_b), .soft_rst(soft_rst),
    .cfg_write(cfg_write), .averaging_select(averaging_select), .wlim_we(wlim_we),
    .wlim_chan(wlim_chan), .wlim_data(wlim_data), .pvu_we(pvu_we), .pvl_we(pvl_we),
    .pv_lim_data(pv_lim_data), .conv(conv), .warning_flags(warning_flags),
    .shunt_avg(shunt_avg), .bus_val(bus_val), .pv_upper_r(pv_upper_r),
    .pv_lower_r(pv_lower_r), .seq_done_r(seq_done_r), .warn_o(w_o), .warn_oe_b(w_oe),
    .power_valid_output_o(p_o), .power_valid_output_oe_b(p_oe),
    .sequence_check_output_o(s_o), .sequence_check_output_oe_b(s_oe));
  ramon_host ramon_host_i (.warn_o(w_o), .warn_oe_b(w_oe), .pv_o(p_o), .pv_oe_b(p_oe),
    .seq_o(s_o), .seq_oe_b(s_oe), .warn_line(wl), .pv_line(pl), .seq_line(sl));
  // =========================================
  // access tasks
  task chk(input string nm, input logic [12:0] seen, input logic [12:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wt
  // one conversion strobe per call, idle strobe ends a burst
  task drv(input logic v, input logic b, input logic [1:0] c, input logic [12:0] d);
    @(negedge clk_sys);
    conv = '{valid: v, is_bus: b, chan: c, value: d};
  endtask : drv
  task bcyc(input logic [12:0] a, input logic [12:0] b, input logic [12:0] c);
    drv(1, 1, 0, a);
    drv(1, 1, 1, b);
    drv(1, 1, 2, c);
    drv(0, 0, 0, 0);
    wt(3);
  endtask : bcyc
  task shunt(input logic [1:0] c, input logic [12:0] d);
    drv(1, 0, c, d);
    drv(0, 0, 0, 0);
    wt(3);
  endtask : shunt
  task pulse(input int k);
    @(negedge clk_sys);
    case (k)
      0: soft_rst = 1;
      1: cfg_write = 1;
      2: wlim_we = 1;
      3: pvu_we = 1;
      default: pvl_we = 1;
    endcase
    @(negedge clk_sys);
    {soft_rst, cfg_write, wlim_we, pvu_we, pvl_we} = 5'h00;
    wt(2);
  endtask : pulse
  task results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  // =========================================
  // test sequence
  initial begin
    repeat (5) @(negedge clk_sys);
    rst_b = 1;
    wt(1);
    chk("pv_upper", pv_upper_r, ramon_pkg::PV_UPPER_RST);
    chk("pv_lower", pv_lower_r, ramon_pkg::PV_LOWER_RST);
    chk("pv_line", pl, 0);
    chk("warn_line", wl, 1);
    $display("test reset done");
    bcyc(13'h0100, 13'h0010, 13'h0010);
    repeat (2) bcyc(13'h0100, 13'h0010, 13'h0010);
    chk("seq_early", sl, 1);
    bcyc(13'h0100, 13'h0010, 13'h0010);
    chk("seq_fail", sl, 0);
    bcyc(13'h0100, 13'h0100, 13'h0100);
    chk("seq_latch", sl, 0);
    pulse(0);
    chk("seq_restart", sl, 1);
    bcyc(13'h0100, 13'h0096, 13'h0010);
    repeat (5) bcyc(13'h0100, 13'h0010, 13'h0010);
    chk("seq_pass", sl, 1);
    pulse(0);
    pulse(1);
    repeat (5) bcyc(13'h0100, 13'h0010, 13'h0010);
    chk("seq_disabled", sl, 1);
    chk("seq_done", seq_done_r, 1);
    $display("test sequence check done");
    bcyc(13'h04e2, 13'h04e2, 13'h04e1);
    chk("pv_partial", pl, 0);
    bcyc(13'h04e2, 13'h04e2, 13'h04e2);
    chk("pv_high", pl, 1);
    drv(1, 1, 0, 13'h0464);
    drv(1, 1, 1, 13'h04e2);
    drv(0, 0, 0, 0);
    wt(3);
    chk("pv_wait", pl, 1);
    chk("bus0", bus_val[0], 13'h0464);
    drv(1, 1, 2, 13'h04e2);
    drv(0, 0, 0, 0);
    wt(3);
    chk("pv_drop", pl, 0);
    chk("bus0_held", bus_val[0], 13'h0464);
    chk("bus1", bus_val[1], 13'h04e2);
    chk("bus2", bus_val[2], 13'h04e2);
    bcyc(13'h0465, 13'h0465, 13'h0465);
    chk("pv_hyst", pl, 0);
    pv_lim_data = 13'h0200;
    pulse(3);
    pulse(4);
    chk("pvu_wr", pv_upper_r, 13'h0200);
    bcyc(13'h0200, 13'h0200, 13'h0200);
    chk("pv_new_lim", pl, 1);
    pulse(0);
    chk("pvu_def", pv_upper_r, ramon_pkg::PV_UPPER_RST);
    chk("pvl_def", pv_lower_r, ramon_pkg::PV_LOWER_RST);
    chk("pv_held", pl, 1);
    bcyc(13'h0300, 13'h0300, 13'h0300);
    chk("pv_reeval", pl, 0);
    $display("test power valid done");
    shunt(1, 13'h0100);
    chk("flags_def", warning_flags, 0);
    for (int c = 0; c < 3; c++) begin
      wlim_chan = c[1:0];
      wlim_data = 13'h0080;
      pulse(2);
      shunt(c[1:0], 13'h0100);
      chk("avg", shunt_avg[c], 13'h0100);
      chk("flags", warning_flags, 13'h0001 << c);
      chk("warn_low", wl, 0);
      shunt(c[1:0], 13'h0010);
      chk("warn_rel", wl, 1);
    end
    averaging_select = 3'h1;
    shunt(1, 13'h0110);
    chk("avg_depth", shunt_avg[1], 13'h0090);
    chk("flags_avg", warning_flags, 13'h0002);
    $display("test warning done");
    results();
  end
endmodule : ramon_top_test
